// ---- tb_uart_auto_flow_control.sv ----
// tb_uart_auto_flow_control: bench for ufc_flow over wishbone.
// assumes: ufc_pkg compiled first; remote model in ufc_remote.
`timescale 1ns/1ps
`default_nettype none
module tb_uart_auto_flow_control import ufc_pkg::*; ();
  logic clk_sys, rst, cyc, stb, we, ack, rts_n, rx_v, st_v, bit_tick;
  logic tx_allow, f_req, f_ack, irq, cts_n, ce;
  logic [3:0] sel;
  logic [7:0] adr, rx_d, st_d, f_char, last_st;
  logic [31:0] dat, dat_o;
  logic [6:0] rx_fill;
  logic [1:0] tcnt;
  int n_mismatch, num_checks, n_st, ticks, t0, dt;
  logic [7:0] pc [4] = '{8'h11, 8'h91, 8'h13, 8'h93}; // pattern chars
  ufc_flow ufc_flow_i (.clk_sys(clk_sys), .rst(rst), .ce(ce),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .cts_n(cts_n), .rts_n(rts_n), .rx_fill(rx_fill), .rx_in_v(rx_v),
    .rx_in_d(rx_d), .rx_store_v(st_v), .rx_store_d(st_d),
    .bit_tick(bit_tick), .tx_allow(tx_allow), .flow_tx_req(f_req),
    .flow_tx_char(f_char), .flow_tx_ack(f_ack), .irq(irq));
  ufc_remote ufc_remote_i (.clk_sys(clk_sys), .rts_n(rts_n),
    .rx_v(rx_v), .rx_d(rx_d), .rmt_rts_n(cts_n));
  // ==================================================================
  // clock, bit ticks every 4 cycles, fifo push monitor
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    tcnt <= tcnt + 2'd1;
    bit_tick <= (tcnt == 2'd3);
    if (bit_tick === 1'b1) ticks <= ticks + 1;
    if (st_v === 1'b1) n_st <= n_st + 1;
    if (st_v === 1'b1) last_st <= st_d;
  end
  // ==================================================================
  // compare, verdict and bus tasks
  task automatic chk(input string nm, input logic [31:0] s, e);
    num_checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      complete_run();
    end
    @(posedge clk_sys);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rdc(input string nm, input logic [7:0] a,
                     input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  // wait for a flow char, check it, take it
  task automatic flow(input logic [7:0] e);
    int n;
    n = 0;
    while (f_req !== 1'b1 && n < 600) begin
      @(posedge clk_sys);
      n++;
    end
    dt = ticks - t0;
    if (n >= 600) n_mismatch++;
    if (n >= 600) complete_run();
    chk("flow_char", f_char, e);
    f_ack <= 1'b1;
    @(posedge clk_sys);
    f_ack <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic fill(input logic [6:0] f);
    rx_fill <= f;
    repeat (6) @(posedge clk_sys);
  endtask
  // ==================================================================
  // main sequence
  initial begin
    {rst, cyc, stb, we, f_ack, bit_tick} = 6'h20;
    ce = 1'b1;
    sel = 4'hf;
    {adr, dat, rx_fill, tcnt} = '0;
    {n_mismatch, num_checks, n_st, ticks} = '0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    chk("rts_reset", rts_n, 1'b1);
    for (int i = 0; i < 4; i++) rdc("pat_rst", ADR_RES1 + 8'(4*i), 0);
    for (int i = 0; i < 4; i++) wr(ADR_RES1 + 8'(4*i), 32'(pc[i]));
    for (int i = 0; i < 4; i++) rdc("pat", ADR_RES1 + 8'(4*i), pc[i]);
    rdc("unmapped", 8'h3c, 32'h0);
    // a write without the low byte lane leaves the register alone
    sel <= 4'he;
    wr(ADR_RES1, 32'h55);
    sel <= 4'hf;
    rdc("sel_lane", ADR_RES1, 32'(pc[0]));
    wr(ADR_IEN, 32'hf1);
    rdc("ien_locked", ADR_IEN, 32'h01);
    wr(ADR_FEAT, 32'h50);
    wr(ADR_IEN, 32'he1);
    rdc("ien", ADR_IEN, 32'he1);
    wr(ADR_TRIG, 32'h09); // table b, level 16, limits 24 and 8
    chk("rts_idle", rts_n, 1'b1);
    wr(ADR_MCTL, 32'h02);
    fill(7'd15);
    chk("rts_on", rts_n, 1'b0);
    fill(7'd16);
    chk("rts_trig", rts_n, 1'b0);
    chk("irq_trig", irq, 1'b1);
    fill(7'd23);
    chk("rts_23", rts_n, 1'b0);
    fill(7'd24);
    chk("rts_24", rts_n, 1'b1);
    ufc_remote_i.send(8'h5a, 1'b1);
    chk("store_held", last_st, 8'h5a);
    fill(7'd9);
    chk("rts_9", rts_n, 1'b1);
    fill(7'd8);
    chk("rts_8", rts_n, 1'b0);
    fill(7'd0);
    wr(ADR_ISTAT, 32'h31);
    ufc_remote_i.set_rts(1'b1);
    chk("cts_ungated", tx_allow, 1'b1);
    ufc_remote_i.set_rts(1'b0);
    wr(ADR_ISTAT, 32'h31);
    wr(ADR_FEAT, 32'hd1); // cts gate, auto rts, single compare
    ufc_remote_i.set_rts(1'b1);
    chk("cts_stop", tx_allow, 1'b0);
    rdc("cts_stat", ADR_ISTAT, 32'h20);
    chk("cts_irq", irq, 1'b1);
    ufc_remote_i.set_rts(1'b0);
    chk("cts_go", tx_allow, 1'b1);
    wr(ADR_ISTAT, 32'h20);
    t0 = n_st;
    ufc_remote_i.send(8'h13, 1'b0);
    chk("xoff_hold", tx_allow, 1'b0);
    rdc("xoff_stat", ADR_ISTAT, 32'h10);
    ufc_remote_i.send(8'h41, 1'b0);
    ufc_remote_i.set_rts(1'b1);
    ufc_remote_i.send(8'h11, 1'b0);
    chk("both_hold", tx_allow, 1'b0);
    rdc("xon_stat", ADR_ISTAT, 32'h20);
    ufc_remote_i.set_rts(1'b0);
    chk("both_free", tx_allow, 1'b1);
    chk("single_st", n_st - t0, 1);
    wr(ADR_FEAT, 32'hd2); // pair compare
    ufc_remote_i.send(8'h13, 1'b0);
    ufc_remote_i.send(8'h41, 1'b0);
    chk("pair_miss", n_st - t0, 3);
    ufc_remote_i.send(8'h13, 1'b0);
    ufc_remote_i.send(8'h93, 1'b0);
    chk("pair_hold", tx_allow, 1'b0);
    ufc_remote_i.send(8'h11, 1'b0);
    ufc_remote_i.send(8'h91, 1'b0);
    chk("pair_free", tx_allow, 1'b1);
    chk("pair_st", n_st - t0, 3);
    wr(ADR_FEAT, 32'hd6); // single xoff/xon sending
    t0 = ticks;
    rx_fill <= 7'd16;
    flow(8'h13);
    chk("xoff_delay", 32'(dt >= 19 && dt <= 21), 1);
    fill(7'd9);
    chk("no_xon_9", f_req, 1'b0);
    fill(7'd8);
    flow(8'h11);
    wr(ADR_TRIG, 32'h00041404); // table d, level 20, hysteresis 4
    rx_fill <= 7'd20;
    flow(8'h13);
    fill(7'd16);
    chk("no_xon_16", f_req, 1'b0);
    fill(7'd15);
    flow(8'h11);
    // clock enable low freezes the rts decision
    ce <= 1'b0;
    fill(7'd40);
    chk("ce_freeze", rts_n, 1'b0);
    ce <= 1'b1;
    fill(7'd40);
    chk("rts_d_up", rts_n, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire

// ---- ufc_flow.sv ----
// ufc_flow: automatic rts/cts and xon/xoff flow control of one uart.
// assumes: receiver, fifo, transmitter and baud tick share clk_sys;
// received characters arrive at least two cycles apart.
//
// Summary of operation
// - rx trigger reached raises receive interrupt
// - rts stays low until upper limit
// - rts low again at lower limit
// - keep storing characters while rts high
// - hysteresis acts only after rts asserted
// - tables a-c use neighbour levels as limits
// - cts gating only with feature bit 7
// - cts interrupt enable needs feature bit 4
// - cts high sets status bit 5
// - cts high stops after current character
// - cts low resumes transmission
// - compare one or two chars to pattern
// - xoff stops after current character
// - xoff sets flag and interrupt if enabled
// - xon resumes and clears status bit 4
// - pattern characters reset to zero
// - double mode needs both characters in order
// - matched flow characters never stored
// - send xoff two char times after trigger
// - tables a-c: xon one step below
// - table d: xon below level minus hysteresis
// - auto rts only with feature bit 6
`timescale 1ns/1ps
`default_nettype none
module ufc_flow
  import ufc_pkg::*;
(
  input  wire logic        clk_sys,      // 250 mhz system clock
  input  wire logic        rst,          // synchronous reset
  input  wire logic        ce,           // clock enable
  input  wire logic        wb_cyc_i,     // bus cycle
  input  wire logic        wb_stb_i,     // bus strobe
  input  wire logic        wb_we_i,      // write enable
  input  wire logic [7:0]  wb_adr_i,     // byte address
  input  wire logic [31:0] wb_dat_i,     // write data
  input  wire logic [3:0]  wb_sel_i,     // byte lanes
  output logic      [31:0] wb_dat_o,     // read data
  output logic             wb_ack_o,     // acknowledge
  input  wire logic        cts_n,        // clear to send pin
  output logic             rts_n,        // request to send pin
  input  wire logic [6:0]  rx_fill,      // receive fifo fill
  input  wire logic        rx_in_v,      // received char valid
  input  wire logic [7:0]  rx_in_d,      // received char
  output logic             rx_store_v,   // push to receive fifo
  output logic      [7:0]  rx_store_d,   // char to push
  input  wire logic        bit_tick,     // one pulse per bit time
  output logic             tx_allow,     // transmitter may start
  output logic             flow_tx_req,  // flow char to send
  output logic      [7:0]  flow_tx_char, // flow char value
  input  wire logic        flow_tx_ack,  // flow char taken
  output logic             irq           // interrupt output
);
  // ==================================================================
  // registers
  logic [7:0]  feat;            // enhanced_feature_reg
  logic [7:0]  ien;             // interrupt_enable_reg
  logic [7:0]  istat;           // interrupt_status_reg
  logic [7:0]  mctl;            // modem_control_reg
  logic [7:0]  res1;            // resume_char_first
  logic [7:0]  res2;            // resume_char_second
  logic [7:0]  pau1;            // pause_char_first
  logic [7:0]  pau2;            // pause_char_second
  logic [19:0] trig;            // trigger control
  logic        cts_meta;        // synchroniser first stage
  logic        cts_s;           // synchronised cts
  logic        cts_d;           // cts delayed for edges
  logic        rts_go;          // rts was asserted once
  logic        xoff_hold;       // suspended by xoff
  logic        above_d;         // fill at trigger last cycle
  logic        pend_v;          // first char of a pair held
  logic [7:0]  pend_d;          // held char
  logic        spill_v;         // char to push next cycle
  logic [7:0]  spill_d;         // spilled char
  logic        off_sent;        // xoff sent, xon owed
  logic        send_off;        // sending the pause pair
  logic [4:0]  dly;             // bit tick counter
  ufc_snd_t    snd;             // sender state
  ufc_snd_t    next_snd;        // sender next state
  logic        next_rts;        // rts pin next value

  // ==================================================================
  // trigger levels
  // picks one entry of a fixed table
  function automatic logic [6:0] lvl(input logic [1:0] tb,
                                     input logic [1:0] ix);
    logic [27:0] t;
    t = (tb == 2'h0) ? TBL_A : (tb == 2'h1) ? TBL_B : TBL_C;
    return t[7*ix +: 7];
  endfunction

  wire [1:0] t_ix  = trig[1:0];           // level index
  wire       t_d   = trig[TRG_TBLD];      // programmable table
  wire [1:0] t_tb  = trig[4:3];           // fixed table choice
  wire [6:0] d_lvl = {1'b0, trig[13:8]};  // programmable level
  wire [6:0] d_hys = {3'h0, trig[19:16]}; // programmable hysteresis
  wire [6:0] trg   = t_d ? d_lvl : lvl(t_tb, t_ix);
  // limits: neighbours in the fixed tables
  // neighbour level limits
  wire [6:0] up_ab = (t_ix == 2'h3) ? FIFO_FULL
                   : lvl(t_tb, t_ix + 2'h1);
  wire [6:0] lo_ab = (t_ix == 2'h0) ? 7'h00
                   : lvl(t_tb, t_ix - 2'h1);
  wire [6:0] upper = t_d ? d_lvl + d_hys : up_ab;
  wire [6:0] lower = t_d ? ((d_lvl > d_hys) ? d_lvl - d_hys : 7'h00)
                   : lo_ab;
  wire       above = rx_fill >= trg;
  // one step under, level minus hysteresis
  wire       xon_ok = t_d ? (rx_fill < lower) : (rx_fill <= lower);

  // ==================================================================
  // bus decode
  wire req   = wb_cyc_i & wb_stb_i & ~wb_ack_o; // new request
  wire wr    = req & wb_we_i;                   // write strobe
  wire wr0   = wr & wb_sel_i[0];                // low byte write
  wire w_ft  = wr0 & (wb_adr_i == ADR_FEAT);
  wire w_ie  = wr0 & (wb_adr_i == ADR_IEN);
  wire w_is  = wr0 & (wb_adr_i == ADR_ISTAT);
  wire w_mc  = wr0 & (wb_adr_i == ADR_MCTL);
  wire w_r1  = wr0 & (wb_adr_i == ADR_RES1);
  wire w_r2  = wr0 & (wb_adr_i == ADR_RES2);
  wire w_p1  = wr0 & (wb_adr_i == ADR_PAU1);
  wire w_p2  = wr0 & (wb_adr_i == ADR_PAU2);
  wire w_tg  = wr & (wb_adr_i == ADR_TRIG);
  wire [7:0] ien_mask = feat[FEAT_ENH] ? 8'hff : 8'h0f;
  wire [31:0] rd =
      (wb_adr_i == ADR_FEAT)  ? {24'h0, feat}  :
      (wb_adr_i == ADR_IEN)   ? {24'h0, ien}   :
      (wb_adr_i == ADR_ISTAT) ? {24'h0, istat} :
      (wb_adr_i == ADR_MCTL)  ? {24'h0, mctl}  :
      (wb_adr_i == ADR_RES1)  ? {24'h0, res1}  :
      (wb_adr_i == ADR_RES2)  ? {24'h0, res2}  :
      (wb_adr_i == ADR_PAU1)  ? {24'h0, pau1}  :
      (wb_adr_i == ADR_PAU2)  ? {24'h0, pau2}  :
      (wb_adr_i == ADR_TRIG)  ? {12'h0, trig}  :
      (wb_adr_i == ADR_STAT)  ? {16'h0, 1'b0, rx_fill, 3'h0,
                                 off_sent, pend_v, xoff_hold,
                                 ~tx_allow, rts_n} : 32'h0;

  // ==================================================================
  // character matching
  wire sw_one = feat[1:0] == 2'h1;   // single char compare
  wire sw_two = feat[1:0] == 2'h2;   // pair compare
  wire tx_one = feat[3:2] == 2'h1;   // send single chars
  wire tx_two = feat[3:2] == 2'h2;   // send pairs
  wire tx_en  = tx_one | tx_two;
  wire hit_off = rx_in_v & (sw_one ? rx_in_d == pau1
               : sw_two & pend_v & pend_d == pau1 & rx_in_d == pau2);
  wire hit_on  = rx_in_v & (sw_one ? rx_in_d == res1
               : sw_two & pend_v & pend_d == res1 & rx_in_d == res2);
  wire first   = sw_two & (rx_in_d == pau1 | rx_in_d == res1)
               & ~hit_off & ~hit_on;
  wire cts_rise = cts_s & ~cts_d;      // cts deasserted
  wire rts_rise = next_rts & ~rts_n;   // rts deasserted

  // ==================================================================
  // rts hysteresis
  always_comb begin
    next_rts = rts_n;
    if (!mctl[MCTL_RTS]) begin
      next_rts = 1'b1;
    end else if (!feat[FEAT_RTS] || !rts_go) begin
      next_rts = 1'b0;
    end else if (!rts_n && rx_fill >= upper) begin
      next_rts = 1'b1;
    end else if (rts_n && rx_fill <= lower) begin
      next_rts = 1'b0;
    end
  end

  // ==================================================================
  // bus slave: ack and read data one cycle after the request
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else if (ce) begin
      wb_ack_o <= req;
      wb_dat_o <= rd;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      feat <= RST_BYTE;
      ien  <= RST_BYTE;
      mctl <= RST_BYTE;
      res1 <= RST_BYTE;
      res2 <= RST_BYTE;
      pau1 <= RST_BYTE;
      pau2 <= RST_BYTE;
      trig <= RST_TRIG;
    end else if (ce) begin
      if (w_ft) feat <= wb_dat_i[7:0];
      if (w_ie) ien <= wb_dat_i[7:0] & ien_mask;
      if (w_mc) mctl <= wb_dat_i[7:0];
      if (w_r1) res1 <= wb_dat_i[7:0];
      if (w_r2) res2 <= wb_dat_i[7:0];
      if (w_p1) pau1 <= wb_dat_i[7:0];
      if (w_p2) pau2 <= wb_dat_i[7:0];
      if (w_tg && wb_sel_i[0]) trig[7:0]   <= wb_dat_i[7:0];
      if (w_tg && wb_sel_i[1]) trig[15:8]  <= wb_dat_i[15:8];
      if (w_tg && wb_sel_i[2]) trig[19:16] <= wb_dat_i[19:16];
    end
  end

  // ==================================================================
  // cts synchroniser and edge history
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cts_meta <= 1'b0;
      cts_s    <= 1'b0;
      cts_d    <= 1'b0;
    end else if (ce) begin
      cts_meta <= cts_n;
      cts_s    <= cts_meta;
      cts_d    <= cts_s;
    end
  end

  // rts pin and start flag
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rts_n  <= 1'b1;
      rts_go <= 1'b0;
    end else if (ce) begin
      rts_n  <= next_rts;
      rts_go <= mctl[MCTL_RTS] & (rts_go | ~rts_n);
    end
  end

  // ==================================================================
  // interrupt status: hardware set wins over software clear
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      istat   <= RST_BYTE;
      above_d <= 1'b0;
      irq     <= 1'b0;
    end else if (ce) begin
      above_d <= above;
      irq     <= |istat;
      if (w_is) istat <= istat & ~wb_dat_i[7:0];
      if (above && !above_d && ien[IEN_RXT]) istat[IST_RXT] <= 1'b1;
      if (hit_on) istat[IST_XOFF] <= 1'b0;
      if (hit_off && ien[IEN_XOFF]) istat[IST_XOFF] <= 1'b1;
      if (cts_rise && ien[IEN_CTS]) istat[IST_MODEM] <= 1'b1;
      if (rts_rise && ien[IEN_RTS]) istat[IST_MODEM] <= 1'b1;
    end
  end

  // ==================================================================
  // transmit gating, sampled by the transmitter at character start
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      xoff_hold <= 1'b0;
      tx_allow  <= 1'b0;
    end else if (ce) begin
      if (!sw_one && !sw_two) xoff_hold <= 1'b0;
      else if (hit_off) xoff_hold <= 1'b1;
      else if (hit_on) xoff_hold <= 1'b0;
      tx_allow <= ~((feat[FEAT_CTS] & cts_s) | xoff_hold | hit_off);
    end
  end

  // ==================================================================
  // receive path: drops matched flow chars, holds pair heads
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_store_v <= 1'b0;
      rx_store_d <= 8'h00;
      pend_v     <= 1'b0;
      pend_d     <= 8'h00;
      spill_v    <= 1'b0;
      spill_d    <= 8'h00;
    end else if (ce) begin
      rx_store_v <= spill_v;
      rx_store_d <= spill_d;
      spill_v    <= 1'b0;
      if (rx_in_v) begin
        if (hit_off || hit_on) begin
          pend_v <= 1'b0;
        end else if (pend_v) begin
          // held head was not a pair: release it
          rx_store_v <= 1'b1;
          rx_store_d <= pend_d;
          pend_v     <= first;
          pend_d     <= rx_in_d;
          spill_v    <= ~first;
          spill_d    <= rx_in_d;
        end else if (first) begin
          pend_v <= 1'b1;
          pend_d <= rx_in_d;
        end else begin
          rx_store_v <= 1'b1;
          rx_store_d <= rx_in_d;
        end
      end
    end
  end

  // ==================================================================
  // flow character sender
  always_comb begin
    next_snd = snd;
    case (snd)
      UFC_IDLE: begin
        if (tx_en && !off_sent && above) next_snd = UFC_WAIT;
        else if (tx_en && off_sent && xon_ok) next_snd = UFC_CH1;
      end
      UFC_WAIT: begin
        if (bit_tick && dly == DELAY_BITS - 5'h01) next_snd = UFC_CH1;
      end
      UFC_CH1: begin
        if (flow_tx_ack) next_snd = tx_two ? UFC_CH2 : UFC_IDLE;
      end
      UFC_CH2: begin
        if (flow_tx_ack) next_snd = UFC_IDLE;
      end
      default: next_snd = UFC_IDLE;
    endcase
  end

  // sender registers and the character handed to the transmitter
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      snd          <= UFC_IDLE;
      dly          <= 5'h00;
      off_sent     <= 1'b0;
      send_off     <= 1'b0;
      flow_tx_req  <= 1'b0;
      flow_tx_char <= 8'h00;
    end else if (ce) begin
      snd <= next_snd;
      if (!tx_en) off_sent <= 1'b0;
      if (snd == UFC_IDLE) begin
        dly      <= 5'h00;
        send_off <= ~off_sent;
      end
      if (snd == UFC_WAIT && bit_tick) dly <= dly + 5'h01;
      flow_tx_req <= next_snd == UFC_CH1 || next_snd == UFC_CH2;
      if (next_snd == UFC_CH1) begin
        flow_tx_char <= (snd == UFC_WAIT) ? pau1 : res1;
      end
      if (next_snd == UFC_CH2) begin
        flow_tx_char <= send_off ? pau2 : res2;
      end
      if (snd != UFC_IDLE && next_snd == UFC_IDLE) off_sent <= send_off;
    end
  end

  // ==================================================================
  // checks
  property p_rts_up;
    @(posedge clk_sys) disable iff (rst)
    ce && mctl[MCTL_RTS] && feat[FEAT_RTS] && rts_go && !rts_n
      && rx_fill >= upper |=> rts_n;
  endproperty
  a_rts_up: assert property (p_rts_up)
    else $error("rts not raised at upper limit");

  property p_rts_down;
    @(posedge clk_sys) disable iff (rst)
    ce && mctl[MCTL_RTS] && feat[FEAT_RTS] && rts_n && rts_go
      && rx_fill <= lower |=> !rts_n;
  endproperty
  a_rts_down: assert property (p_rts_down)
    else $error("rts not lowered at lower limit");

  property p_cts_gate;
    @(posedge clk_sys) disable iff (rst)
    ce && feat[FEAT_CTS] && cts_s |=> !tx_allow;
  endproperty
  a_cts_gate: assert property (p_cts_gate)
    else $error("transmit allowed while cts high");

  property p_cts_irq;
    @(posedge clk_sys) disable iff (rst)
    ce && cts_rise && ien[IEN_CTS] |=> istat[IST_MODEM] ##1 irq;
  endproperty
  a_cts_irq: assert property (p_cts_irq)
    else $error("cts edge did not flag");

  property p_xoff_stop;
    @(posedge clk_sys) disable iff (rst)
    ce && hit_off |=> !tx_allow && xoff_hold;
  endproperty
  a_xoff_stop: assert property (p_xoff_stop)
    else $error("xoff did not suspend");

  property p_drop;
    @(posedge clk_sys) disable iff (rst)
    ce && (hit_off || hit_on) && !spill_v |=> !rx_store_v;
  endproperty
  a_drop: assert property (p_drop)
    else $error("flow char stored");

  property p_xon_clear;
    @(posedge clk_sys) disable iff (rst)
    ce && hit_on |=> !istat[IST_XOFF] && !xoff_hold;
  endproperty
  a_xon_clear: assert property (p_xon_clear)
    else $error("xon did not clear flag");

  property p_trig_irq;
    @(posedge clk_sys) disable iff (rst)
    ce && above && !above_d && ien[IEN_RXT] |=> istat[IST_RXT];
  endproperty
  a_trig_irq: assert property (p_trig_irq)
    else $error("trigger interrupt missing");
endmodule
`default_nettype wire

// ---- ufc_pkg.sv ----
// ufc_pkg: register map, field positions, trigger tables and timing
// counts for the uart flow control block.
// assumes: one 250 MHz system clock and a 32-bit wishbone slave port.
`default_nettype none
package ufc_pkg;
  // ==================================================================
  // register byte offsets
  localparam logic [7:0] ADR_FEAT  = 8'h00; // enhanced_feature_reg
  localparam logic [7:0] ADR_IEN   = 8'h04; // interrupt_enable_reg
  localparam logic [7:0] ADR_ISTAT = 8'h08; // interrupt_status_reg
  localparam logic [7:0] ADR_MCTL  = 8'h0c; // modem_control_reg
  localparam logic [7:0] ADR_RES1  = 8'h10; // resume_char_first
  localparam logic [7:0] ADR_RES2  = 8'h14; // resume_char_second
  localparam logic [7:0] ADR_PAU1  = 8'h18; // pause_char_first
  localparam logic [7:0] ADR_PAU2  = 8'h1c; // pause_char_second
  localparam logic [7:0] ADR_TRIG  = 8'h20; // trigger control
  localparam logic [7:0] ADR_STAT  = 8'h24; // block status, read only
  // ==================================================================
  // field positions
  localparam int FEAT_CTS   = 7; // auto cts gating
  localparam int FEAT_RTS   = 6; // auto rts control
  localparam int FEAT_ENH   = 4; // enhanced function unlock
  localparam int IEN_RXT    = 0; // rx trigger interrupt
  localparam int IEN_XOFF   = 5; // xoff interrupt
  localparam int IEN_RTS    = 6; // rts interrupt
  localparam int IEN_CTS    = 7; // cts interrupt
  localparam int IST_RXT    = 0; // rx trigger reached
  localparam int IST_XOFF   = 4; // xoff received
  localparam int IST_MODEM  = 5; // cts or rts went high
  localparam int MCTL_RTS   = 1; // rts request
  localparam int TRG_TBLD   = 2; // programmable table select
  // ==================================================================
  // reset values
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [19:0] RST_TRIG = 20'h00000;
  // ==================================================================
  // fixed trigger tables, level 3 in the top seven bits
  localparam logic [27:0] TBL_A = {7'h0e, 7'h08, 7'h04, 7'h01};
  localparam logic [27:0] TBL_B = {7'h1c, 7'h18, 7'h10, 7'h08};
  localparam logic [27:0] TBL_C = {7'h3c, 7'h38, 7'h10, 7'h08};
  localparam logic [6:0]  FIFO_FULL = 7'h40;
  // ==================================================================
  // xoff send delay: two character times counted in bit ticks
  localparam int DELAY_CHARS = 2;
  localparam int FRAME_BITS  = 10;
  localparam logic [4:0] DELAY_BITS = 5'(DELAY_CHARS * FRAME_BITS);
  // ==================================================================
  // flow character sender states
  typedef enum logic [1:0] {UFC_IDLE, UFC_WAIT, UFC_CH1, UFC_CH2}
    ufc_snd_t;
endpackage
`default_nettype wire

// ---- ufc_remote.sv ----
// ufc_remote: remote uart model, sends chars and drives our cts.
// assumes: shares clk_sys; the bench calls send and set_rts.
`timescale 1ns/1ps
`default_nettype none
module ufc_remote (
  input  wire logic       clk_sys, // system clock
  input  wire logic       rts_n,   // our rts, remote cts
  output logic            rx_v,    // char valid pulse
  output logic      [7:0] rx_d,    // char value
  output logic            rmt_rts_n // remote rts, our cts
);
  // idle line state
  initial begin
    rx_v = 1'b0;
    rx_d = 8'h00;
    rmt_rts_n = 1'b0;
  end
  // ==================================================================
  // one char; a remote waits for cts unless already in flight (push)
  task automatic send(input logic [7:0] c, input logic push);
    int n;
    n = 0;
    while (rts_n !== 1'b0 && !push && n < 400) begin
      @(posedge clk_sys);
      n++;
    end
    rx_v <= 1'b1;
    rx_d <= c;
    @(posedge clk_sys);
    rx_v <= 1'b0;
    rx_d <= ~c; // stale data never looks valid
    repeat (3) @(posedge clk_sys);
  endtask
  // remote rts level, seen as our cts
  task automatic set_rts(input logic v);
    rmt_rts_n <= v;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire
